// file: inc/fskrl_map.vh
`ifndef FSKRL_MAP_VH
`define FSKRL_MAP_VH

// Register indices; the byte address on the bus is four times the index.
`define FSKRL_IDX_SPACE_AMP   8'h63
`define FSKRL_IDX_SPACE_FREQ  8'h64
`define FSKRL_IDX_MARK_AMP    8'h65
`define FSKRL_IDX_MARK_FREQ   8'h66
`define FSKRL_IDX_RISE_GAIN   8'h67
`define FSKRL_IDX_FALL_GAIN   8'h68
`define FSKRL_IDX_MODE        8'h6C
`define FSKRL_IDX_RELOAD      8'h20
`define FSKRL_IDX_NORM_AMP    8'h70
`define FSKRL_IDX_NORM_FREQ   8'h71
`define FSKRL_IDX_TIMER       8'h72
`define FSKRL_IDX_SYMBOL      8'h73
`define FSKRL_IDX_STATUS      8'h74

// Field positions.
`define FSKRL_MODE_FSK_MODE_ENABLE_BIT  6
`define FSKRL_MODE_FLUSH_BIT  0
`define FSKRL_RELOAD_REL_BIT  6
`define FSKRL_SYMBOL_BIT      0

// Reset values.
`define FSKRL_COEF_RST        16'h0000
`define FSKRL_GAIN_RST        16'h8000
`define FSKRL_TIMER_RST       16'h0000

// Timing: one oscillator sample period, derived into clock cycles.
`define FSKRL_CLK_PERIOD_NS   25
`define FSKRL_SAMPLE_NS       125000
`define FSKRL_SAMPLE_CYC      (`FSKRL_SAMPLE_NS / `FSKRL_CLK_PERIOD_NS)

// Gain correction is an unsigned fixed-point factor with this many
// fraction bits, so the reset value above means unity gain.
`define FSKRL_GAIN_FRAC       15

`endif

// file: src/fskrl_fifo.v
`timescale 1ns/10ps
`default_nettype none

module fskrl_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             mclk_i,
    input  wire             rst_n_i,
    // Control
    input  wire             flush_i,
    // Fill side
    input  wire             in_valid_i,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             in_ready_o,
    // Drain side
    output wire             out_valid_o,
    output wire [WIDTH-1:0] out_data_o,
    input  wire             out_ready_i,
    // Status
    output wire [AW:0]      level_o
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;

    wire push;
    wire pop;

    assign in_ready_o  = (count_q != DEPTH[AW:0]);
    assign out_valid_o = (count_q != {(AW+1){1'b0}});
    assign out_data_o  = mem_q[rd_ptr_q];
    assign level_o     = count_q;
    assign push        = in_valid_i & in_ready_o & ~flush_i;
    assign pop         = out_valid_o & out_ready_i & ~flush_i;

    always @(posedge mclk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
                            {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
                            {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// file: src/fskrl_top.v
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "fskrl_map.vh"

module fskrl_top #(
    parameter SAMPLE_CYC = `FSKRL_SAMPLE_CYC,
    parameter SYM_DEPTH  = 32,
    parameter SYM_AW     = 5,
    parameter GAIN_FRAC  = `FSKRL_GAIN_FRAC
) (
    // Clock and reset
    input  wire        mclk_i,
    input  wire        rst_n_i,
    // Avalon-MM slave
    input  wire [9:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output wire [31:0] avs_readdata_o,
    output wire        avs_waitrequest_o,
    // Oscillator 1 coefficient load
    output wire [15:0] osc_one_amplitude_coef_o,
    output wire [15:0] osc_one_frequency_coef_o,
    output wire        osc_one_load_o,
    output wire        fsk_symbol_o
);

    localparam [15:0] GAIN_UNITY = 16'h8000;

    // Transfer state machine of the bus slave, one-hot.
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_ACK  = 3'b010;
    localparam [2:0] ST_REST = 3'b100;

    // Coefficient and control registers.
    reg [15:0] fsk_space_amplitude_q;
    reg [15:0] fsk_space_frequency_q;
    reg [15:0] fsk_mark_amplitude_q;
    reg [15:0] fsk_mark_frequency_q;
    reg [15:0] fsk_rise_gain_correction_q;
    reg [15:0] fsk_fall_gain_correction_q;
    reg [15:0] osc_one_amplitude_coef_q;
    reg [15:0] osc_one_frequency_coef_q;
    reg [15:0] osc_one_active_timer_q;
    reg        fsk_mode_enable_q;
    reg        oscillator_reload_enable_q;
    reg        flush_q;

    // Bus slave state.
    reg [2:0]  bus_st_q;
    reg [2:0]  bus_st_d;
    reg        waitreq_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;

    // Sample tick divider and active timer.
    reg [12:0] div_q;
    reg        tick_q;
    reg [15:0] timer_cnt_q;
    reg [15:0] expiry_cnt_q;

    // Oscillator 1 outputs.
    reg [15:0] amp_out_q;
    reg [15:0] freq_out_q;
    reg        load_q;
    reg        symbol_q;

    // Symbol queue hookup.
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [0:0] fifo_out_data;
    wire       fifo_pop;
    wire [SYM_AW:0] fifo_level;

    wire [7:0] idx;
    wire       req;
    wire       sym_write;
    wire       can_accept;
    wire       do_write;
    wire       enhanced;
    wire       expire;
    wire       next_sym;
    wire       rising;
    wire       falling;

    reg  [15:0] base_amp;
    reg  [15:0] base_freq;
    reg  [31:0] gain_prod;
    reg  [15:0] gain_sel;
    reg  [15:0] amp_next;

    assign idx       = avs_address_i[9:2];
    assign req       = avs_read_i | avs_write_i;
    assign sym_write = avs_write_i && (idx == `FSKRL_IDX_SYMBOL);
    // A symbol write against a full queue stays in wait until room appears.
    assign can_accept = ~sym_write | fifo_in_ready;
    assign do_write   = (bus_st_q == ST_ACK) && avs_write_i;

    assign enhanced = fsk_mode_enable_q & oscillator_reload_enable_q;
    assign expire   = tick_q && (osc_one_active_timer_q != 16'h0000) &&
                      (timer_cnt_q == 16'h0000);
    // An empty queue holds the line at mark, the idle state of FSK.
    assign next_sym = fifo_out_valid ? fifo_out_data[0] : 1'b1;
    assign fifo_pop = expire & enhanced & fifo_out_valid;
    assign rising   = ~symbol_q & next_sym;
    assign falling  = symbol_q & ~next_sym;

    fskrl_fifo #(
        .WIDTH (1),
        .DEPTH (SYM_DEPTH),
        .AW    (SYM_AW)
    ) u_sym_fifo (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .flush_i     (flush_q),
        .in_valid_i  (do_write && (idx == `FSKRL_IDX_SYMBOL)),
        .in_data_i   (avs_writedata_i[`FSKRL_SYMBOL_BIT]),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_pop),
        .level_o     (fifo_level)
    );

    // Bus slave: a request is answered with one cycle of waitrequest low.
    always @* begin
        bus_st_d = bus_st_q;
        case (bus_st_q)
            ST_IDLE: begin
                if (req && can_accept) begin
                    bus_st_d = ST_ACK;
                end
            end
            ST_ACK: begin
                bus_st_d = ST_REST;
            end
            ST_REST: begin
                bus_st_d = ST_IDLE;
            end
            default: begin
                bus_st_d = ST_IDLE;
            end
        endcase
    end

    always @* begin
        rdata_d = 32'h0000_0000;
        case (idx)
            `FSKRL_IDX_SPACE_AMP:  rdata_d[15:0] = fsk_space_amplitude_q;
            `FSKRL_IDX_SPACE_FREQ: rdata_d[15:0] = fsk_space_frequency_q;
            `FSKRL_IDX_MARK_AMP:   rdata_d[15:0] = fsk_mark_amplitude_q;
            `FSKRL_IDX_MARK_FREQ:  rdata_d[15:0] = fsk_mark_frequency_q;
            `FSKRL_IDX_RISE_GAIN:  rdata_d[15:0] = fsk_rise_gain_correction_q;
            `FSKRL_IDX_FALL_GAIN:  rdata_d[15:0] = fsk_fall_gain_correction_q;
            `FSKRL_IDX_NORM_AMP:   rdata_d[15:0] = osc_one_amplitude_coef_q;
            `FSKRL_IDX_NORM_FREQ:  rdata_d[15:0] = osc_one_frequency_coef_q;
            `FSKRL_IDX_TIMER:      rdata_d[15:0] = osc_one_active_timer_q;
            `FSKRL_IDX_MODE: begin
                rdata_d[`FSKRL_MODE_FSK_MODE_ENABLE_BIT] = fsk_mode_enable_q;
            end
            `FSKRL_IDX_RELOAD: begin
                rdata_d[`FSKRL_RELOAD_REL_BIT] = oscillator_reload_enable_q;
            end
            `FSKRL_IDX_STATUS: begin
                rdata_d[0]     = symbol_q;
                rdata_d[1]     = enhanced;
                rdata_d[2]     = ~fifo_out_valid;
                rdata_d[3]     = ~fifo_in_ready;
                rdata_d[13:8]  = {{(5-SYM_AW){1'b0}}, fifo_level};
                rdata_d[31:16] = expiry_cnt_q;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_st_q  <= ST_IDLE;
            waitreq_q <= 1'b1;
            rdata_q   <= 32'h0000_0000;
        end else begin
            bus_st_q  <= bus_st_d;
            waitreq_q <= ~((bus_st_q == ST_IDLE) && req && can_accept);
            if ((bus_st_q == ST_IDLE) && avs_read_i) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // Register writes.
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fsk_space_amplitude_q      <= `FSKRL_COEF_RST;
            fsk_space_frequency_q      <= `FSKRL_COEF_RST;
            fsk_mark_amplitude_q       <= `FSKRL_COEF_RST;
            fsk_mark_frequency_q       <= `FSKRL_COEF_RST;
            fsk_rise_gain_correction_q <= `FSKRL_GAIN_RST;
            fsk_fall_gain_correction_q <= `FSKRL_GAIN_RST;
            osc_one_amplitude_coef_q   <= `FSKRL_COEF_RST;
            osc_one_frequency_coef_q   <= `FSKRL_COEF_RST;
            osc_one_active_timer_q     <= `FSKRL_TIMER_RST;
            fsk_mode_enable_q          <= 1'b0;
            oscillator_reload_enable_q <= 1'b0;
            flush_q                    <= 1'b0;
        end else begin
            flush_q <= 1'b0;
            if (do_write) begin
                case (idx)
                    `FSKRL_IDX_SPACE_AMP:
                        fsk_space_amplitude_q <= avs_writedata_i[15:0];
                    `FSKRL_IDX_SPACE_FREQ:
                        fsk_space_frequency_q <= avs_writedata_i[15:0];
                    `FSKRL_IDX_MARK_AMP:
                        fsk_mark_amplitude_q <= avs_writedata_i[15:0];
                    `FSKRL_IDX_MARK_FREQ:
                        fsk_mark_frequency_q <= avs_writedata_i[15:0];
                    `FSKRL_IDX_RISE_GAIN:
                        fsk_rise_gain_correction_q <= avs_writedata_i[15:0];
                    `FSKRL_IDX_FALL_GAIN:
                        fsk_fall_gain_correction_q <= avs_writedata_i[15:0];
                    `FSKRL_IDX_NORM_AMP:
                        osc_one_amplitude_coef_q <= avs_writedata_i[15:0];
                    `FSKRL_IDX_NORM_FREQ:
                        osc_one_frequency_coef_q <= avs_writedata_i[15:0];
                    `FSKRL_IDX_TIMER:
                        osc_one_active_timer_q <= avs_writedata_i[15:0];
                    `FSKRL_IDX_MODE: begin
                        fsk_mode_enable_q <=
                            avs_writedata_i[`FSKRL_MODE_FSK_MODE_ENABLE_BIT];
                        flush_q <= avs_writedata_i[`FSKRL_MODE_FLUSH_BIT];
                    end
                    `FSKRL_IDX_RELOAD: begin
                        oscillator_reload_enable_q <=
                            avs_writedata_i[`FSKRL_RELOAD_REL_BIT];
                    end
                    default: begin
                        flush_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Sample tick divider.
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q  <= 13'h0000;
            tick_q <= 1'b0;
        end else if (div_q == SAMPLE_CYC[12:0] - 13'h0001) begin
            div_q  <= 13'h0000;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 13'h0001;
            tick_q <= 1'b0;
        end
    end

    // Active timer of oscillator 1: counts samples, reloads on expiry.
    // A timer value of zero stops the oscillator from reloading at all.
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_cnt_q  <= 16'h0000;
            expiry_cnt_q <= 16'h0000;
        end else if (tick_q) begin
            if (osc_one_active_timer_q == 16'h0000) begin
                timer_cnt_q <= 16'h0000;
            end else if (timer_cnt_q == 16'h0000) begin
                timer_cnt_q  <= osc_one_active_timer_q - 16'h0001;
                expiry_cnt_q <= expiry_cnt_q + 16'h0001;
            end else begin
                timer_cnt_q <= timer_cnt_q - 16'h0001;
            end
        end
    end

    // Coefficient selection for the reload at expiry.
    always @* begin
        base_amp  = osc_one_amplitude_coef_q;
        base_freq = osc_one_frequency_coef_q;
        gain_sel  = GAIN_UNITY;
        if (enhanced) begin
            if (next_sym) begin
                base_amp  = fsk_mark_amplitude_q;
                base_freq = fsk_mark_frequency_q;
            end else begin
                base_amp  = fsk_space_amplitude_q;
                base_freq = fsk_space_frequency_q;
            end
            if (rising) begin
                gain_sel = fsk_rise_gain_correction_q;
            end else if (falling) begin
                gain_sel = fsk_fall_gain_correction_q;
            end
        end
        gain_prod = base_amp * gain_sel;
        amp_next  = gain_prod[GAIN_FRAC +: 16];
    end

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            amp_out_q  <= 16'h0000;
            freq_out_q <= 16'h0000;
            load_q     <= 1'b0;
            symbol_q   <= 1'b1;
        end else begin
            load_q <= expire;
            if (expire) begin
                amp_out_q  <= amp_next;
                freq_out_q <= base_freq;
                if (enhanced) begin
                    symbol_q <= next_sym;
                end
            end
        end
    end

    assign avs_readdata_o           = rdata_q;
    assign avs_waitrequest_o        = waitreq_q;
    assign osc_one_amplitude_coef_o = amp_out_q;
    assign osc_one_frequency_coef_o = freq_out_q;
    assign osc_one_load_o           = load_q;
    assign fsk_symbol_o             = symbol_q;

endmodule

`default_nettype wire

// file: verif/fskrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "fskrl_map.vh"

module fskrl_assertions #(
    parameter GAIN_FRAC = 15
) (
    // Clock and reset
    input wire logic        mclk_i,
    input wire logic        rst_n_i,
    // Register bus
    input wire logic [9:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    // Oscillator load
    input wire logic [15:0] osc_one_amplitude_coef_o,
    input wire logic [15:0] osc_one_frequency_coef_o,
    input wire logic        osc_one_load_o,
    input wire logic        fsk_symbol_o
);
    logic [15:0] sa_q, sf_q, ma_q, mf_q, rg_q, fg_q, na_q, nf_q;
    logic        fsk_q;
    logic        rel_q;
    logic        enh;
    logic [31:0] rise_p;
    logic [31:0] fall_p;

    // Shadow copies of the registers, taken when a write is answered.
    assign enh    = fsk_q & rel_q;
    assign rise_p = (ma_q * rg_q) >> GAIN_FRAC;
    assign fall_p = (sa_q * fg_q) >> GAIN_FRAC;

    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {sa_q, sf_q, ma_q, mf_q, na_q, nf_q} <= {6{16'h0000}};
            rg_q  <= 16'h8000;
            fg_q  <= 16'h8000;
            fsk_q <= 1'b0;
            rel_q <= 1'b0;
        end else if (avs_write_i && !avs_waitrequest_o) begin
            case (avs_address_i[9:2])
                `FSKRL_IDX_SPACE_AMP:  sa_q <= avs_writedata_i[15:0];
                `FSKRL_IDX_SPACE_FREQ: sf_q <= avs_writedata_i[15:0];
                `FSKRL_IDX_MARK_AMP:   ma_q <= avs_writedata_i[15:0];
                `FSKRL_IDX_MARK_FREQ:  mf_q <= avs_writedata_i[15:0];
                `FSKRL_IDX_RISE_GAIN:  rg_q <= avs_writedata_i[15:0];
                `FSKRL_IDX_FALL_GAIN:  fg_q <= avs_writedata_i[15:0];
                `FSKRL_IDX_NORM_AMP:   na_q <= avs_writedata_i[15:0];
                `FSKRL_IDX_NORM_FREQ:  nf_q <= avs_writedata_i[15:0];
                `FSKRL_IDX_MODE:       fsk_q <= avs_writedata_i[6];
                `FSKRL_IDX_RELOAD:     rel_q <= avs_writedata_i[6];
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_space_ld;
        osc_one_load_o && enh && !fsk_symbol_o;
    endsequence
    sequence s_mark_ld;
        osc_one_load_o && enh && fsk_symbol_o;
    endsequence

    AST_SPACE_AMP: assert property (
        s_space_ld ##0 !$past(fsk_symbol_o) |->
        osc_one_amplitude_coef_o == sa_q) else $error("space amplitude");
    AST_SPACE_FREQ: assert property (
        s_space_ld |-> osc_one_frequency_coef_o == sf_q)
        else $error("space frequency");
    AST_MARK_AMP: assert property (
        s_mark_ld ##0 $past(fsk_symbol_o) |->
        osc_one_amplitude_coef_o == ma_q) else $error("mark amplitude");
    AST_MARK_FREQ: assert property (
        s_mark_ld |-> osc_one_frequency_coef_o == mf_q)
        else $error("mark frequency");
    AST_RISE_GAIN: assert property (
        s_mark_ld ##0 !$past(fsk_symbol_o) |->
        osc_one_amplitude_coef_o == rise_p[15:0]) else $error("rise gain");
    AST_FALL_GAIN: assert property (
        s_space_ld ##0 $past(fsk_symbol_o) |->
        osc_one_amplitude_coef_o == fall_p[15:0]) else $error("fall gain");
    AST_NORMAL: assert property (
        osc_one_load_o && !enh |-> osc_one_amplitude_coef_o == na_q &&
        osc_one_frequency_coef_o == nf_q && $stable(fsk_symbol_o))
        else $error("normal reload");
    AST_LOAD_CAUSE: assert property (
        osc_one_load_o || ($stable(osc_one_amplitude_coef_o) &&
        $stable(osc_one_frequency_coef_o) && $stable(fsk_symbol_o)))
        else $error("outputs changed without a load");
    AST_LOAD_PULSE: assert property (
        osc_one_load_o |=> !osc_one_load_o) else $error("load too long");
    AST_WAIT_PULSE: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    AST_READ_ANSWER: assert property (
        $rose(avs_read_i) |-> ##[1:6] !avs_waitrequest_o)
        else $error("read not answered");
endmodule

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fskrl_map.vh"

module tb_top;
    localparam [31:0] SA = 32'h1234, SF = 32'h2345, MA = 32'h3456;
    localparam [31:0] MF = 32'h4567, RG = 32'h4000, FG = 32'hC000;
    localparam [31:0] NA = 32'h5678, NF = 32'h6789;
    logic        mclk_i;
    logic        rst_n_i;
    logic [9:0]  avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    wire  [31:0] avs_readdata_o;
    wire         avs_waitrequest_o;
    wire  [15:0] amp_w;
    wire  [15:0] freq_w;
    wire         load_w;
    wire         sym_w;
    integer      err_total;
    integer      tests_run;
    logic [31:0] rd;
    logic [15:0] la;
    logic [15:0] lf;
    logic        ls;

    fskrl_top #(.SAMPLE_CYC(4)) DUT (
        .mclk_i                  (mclk_i),
        .rst_n_i                 (rst_n_i),
        .avs_address_i           (avs_address_i),
        .avs_read_i              (avs_read_i),
        .avs_write_i             (avs_write_i),
        .avs_writedata_i         (avs_writedata_i),
        .avs_readdata_o          (avs_readdata_o),
        .avs_waitrequest_o       (avs_waitrequest_o),
        .osc_one_amplitude_coef_o(amp_w),
        .osc_one_frequency_coef_o(freq_w),
        .osc_one_load_o          (load_w),
        .fsk_symbol_o            (sym_w)
    );

    always #12.5 mclk_i = ~mclk_i;

    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", tests_run, err_total);
            if (err_total == 0 && tests_run > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    // One bus cycle; the request stands until waitrequest is seen low.
    task bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge mclk_i);
            avs_address_i   <= {idx, 2'b00};
            avs_writedata_i <= d;
            avs_write_i     <= wr;
            avs_read_i      <= !wr;
            @(posedge mclk_i);
            while (avs_waitrequest_o !== 1'b0 && n < 300) begin
                @(posedge mclk_i);
                n = n + 1;
            end
            rd = avs_readdata_o;
            avs_write_i <= 1'b0;
            avs_read_i  <= 1'b0;
            if (n >= 300) begin
                err_total = err_total + 1;
                give_verdict;
            end
        end
    endtask

    task wait_load;
        integer n;
        begin
            n = 0;
            @(posedge mclk_i);
            while (load_w !== 1'b1 && n < 400) begin
                @(posedge mclk_i);
                n = n + 1;
            end
            la = amp_w;
            lf = freq_w;
            ls = sym_w;
            if (n >= 400) begin
                err_total = err_total + 1;
                give_verdict;
            end
        end
    endtask

    function [15:0] exp_amp(input logic s, input logic p);
        logic [31:0] prod;
        begin
            prod = (s ? MA : SA) * (s == p ? 32'h8000 : (s ? RG : FG));
            exp_amp = prod[30:15];
        end
    endfunction

    task test_regs;
        logic [7:0]  idx [8];
        logic [31:0] val [8];
        begin
            check(sym_w, 32'h1);
            bus(0, `FSKRL_IDX_RISE_GAIN, 0);
            check(rd, 32'h8000);
            bus(0, `FSKRL_IDX_FALL_GAIN, 0);
            check(rd, 32'h8000);
            bus(1, 8'h10, 32'hFFFF);
            bus(0, 8'h10, 0);
            check(rd, 32'h0);
            idx = '{`FSKRL_IDX_SPACE_AMP, `FSKRL_IDX_SPACE_FREQ,
                    `FSKRL_IDX_MARK_AMP, `FSKRL_IDX_MARK_FREQ,
                    `FSKRL_IDX_RISE_GAIN, `FSKRL_IDX_FALL_GAIN,
                    `FSKRL_IDX_NORM_AMP, `FSKRL_IDX_NORM_FREQ};
            val = '{SA, SF, MA, MF, RG, FG, NA, NF};
            for (int i = 0; i < 8; i++) begin
                bus(0, idx[i], 0);
                check(rd, (i == 4 || i == 5) ? 32'h8000 : 32'h0);
                bus(1, idx[i], val[i]);
                bus(0, idx[i], 0);
                check(rd, val[i]);
            end
            $display("test_regs done");
        end
    endtask

    task test_gate(input logic [31:0] mode, input logic [31:0] oscillator_reload_enable);
        begin
            bus(1, `FSKRL_IDX_MODE, mode);
            bus(1, `FSKRL_IDX_RELOAD, oscillator_reload_enable);
            bus(1, `FSKRL_IDX_TIMER, 32'h2);
            wait_load;
            check(la, NA);
            check(lf, NF);
            check(ls, 32'h1);
            bus(1, `FSKRL_IDX_TIMER, 32'h0);
            $display("test_gate done");
        end
    endtask

    task test_fsk;
        logic [5:0] sq;
        logic       p;
        begin
            sq = 6'b101100;
            p  = 1'b1;
            bus(1, `FSKRL_IDX_MODE, 32'h40);
            bus(1, `FSKRL_IDX_RELOAD, 32'h40);
            for (int i = 0; i < 5; i++)
                bus(1, `FSKRL_IDX_SYMBOL, {31'h0, sq[i]});
            bus(1, `FSKRL_IDX_TIMER, 32'h2);
            for (int i = 0; i < 6; i++) begin
                wait_load;
                check(lf, sq[i] ? MF : SF);
                check(la, exp_amp(sq[i], p));
                check(ls, sq[i]);
                p = sq[i];
            end
            bus(1, `FSKRL_IDX_TIMER, 32'h0);
            $display("test_fsk done");
        end
    endtask

    task test_fifo;
        begin
            for (int i = 0; i < 32; i++)
                bus(1, `FSKRL_IDX_SYMBOL, i % 2);
            bus(0, `FSKRL_IDX_STATUS, 0);
            check(rd[3], 32'h1);
            check(rd[1], 32'h1);
            check(rd[13:8], 32'h20);
            bus(1, `FSKRL_IDX_TIMER, 32'h1);
            bus(1, `FSKRL_IDX_SYMBOL, 32'h1);
            bus(1, `FSKRL_IDX_MODE, 32'h41);
            bus(0, `FSKRL_IDX_STATUS, 0);
            check(rd[2], 32'h1);
            bus(1, `FSKRL_IDX_TIMER, 32'h0);
            $display("test_fifo done");
        end
    endtask

    initial begin
        mclk_i          = 1'b0;
        rst_n_i         = 1'b0;
        avs_address_i   = 10'h000;
        avs_read_i      = 1'b0;
        avs_write_i     = 1'b0;
        avs_writedata_i = 32'h0;
        err_total       = 0;
        tests_run       = 0;
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        test_regs;
        test_gate(32'h0, 32'h40);
        test_fsk;
        test_gate(32'h40, 32'h0);
        bus(1, `FSKRL_IDX_RELOAD, 32'h40);
        test_fifo;
        give_verdict;
    end
endmodule

bind fskrl_top fskrl_assertions #(.GAIN_FRAC(GAIN_FRAC)) u_chk (
    .mclk_i                  (mclk_i),
    .rst_n_i                 (rst_n_i),
    .avs_address_i           (avs_address_i),
    .avs_read_i              (avs_read_i),
    .avs_write_i             (avs_write_i),
    .avs_writedata_i         (avs_writedata_i),
    .avs_readdata_o          (avs_readdata_o),
    .avs_waitrequest_o       (avs_waitrequest_o),
    .osc_one_amplitude_coef_o(osc_one_amplitude_coef_o),
    .osc_one_frequency_coef_o(osc_one_frequency_coef_o),
    .osc_one_load_o          (osc_one_load_o),
    .fsk_symbol_o            (fsk_symbol_o)
);

`default_nettype wire
